// ### cdsm_pkg.sv
// Package of register offsets, field positions and reset values
package cdsm_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] FAULT_FLAGS_ADDR       = 8'h05;
	localparam logic [7:0] DRIVE_CONFIG_ADDR      = 8'h06;
	localparam logic [7:0] RESONANCE_SETTING_ADDR = 8'h07;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FAULT_FLAGS_RST        = 8'h00;
	localparam logic [7:0] DRIVE_CONFIG_RST       = 8'h00;
	localparam logic [7:0] RESONANCE_SETTING_RST  = 8'h83;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OVERCURRENT_BIT   = 0;
	localparam int UNDERVOLT_BIT     = 1;
	localparam int COIL_OPEN_BIT     = 2;
	localparam int COIL_SHORT_BIT    = 3;
	localparam int THERMAL_TRIP_BIT  = 4;
	localparam int FAULT_WIDTH       = 5;
	localparam int SETTLE_SEL_BIT    = 0;
	localparam int DRIVE_STYLE_BIT   = 1;
	localparam int RATE_LSB          = 2;
	localparam int RATE_MSB          = 4;
	localparam int DRIVE_CONFIG_MASK_W = 5;
	// ----------------------------------------------------------------
	// Switching-rate codes
	// ----------------------------------------------------------------
	localparam logic [2:0] RATE_0M5 = 3'h0;
	localparam logic [2:0] RATE_1M  = 3'h1;
	localparam logic [2:0] RATE_2M  = 3'h3;
	localparam logic [2:0] RATE_4M8 = 3'h5;
	localparam logic [2:0] RATE_6M  = 3'h6;
	localparam logic [2:0] RATE_4M  = 3'h7;
endpackage

// ### cdsm_regs.sv
// Fault, drive-config and resonance-setting register bank
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Every fault flag clears when the device moves from standby to active, except a fault reported in that same cycle.
// - A thermal trip forces standby and blocks activation until it clears; a trip event in the activation cycle is latched, yet the device goes active.
// - Fault flags sit at bits 0..4 of a read-only register resetting to zero.
// - Settling select 0 picks two resonance periods, 1 picks one period.
// - Drive style 0 is PWM and 1 is linear, PWM out of reset.
// - The three-bit rate code picks the PWM frequency; 010 and 100 unused.
// - The resonance code covers resonance frequencies from 50 to 150 Hz.
// - The resonance register resets to 1000 0011 for 76.2 Hz.
// - Soft reset returns all registers to defaults, keeping faults reported in the same cycle, and forces standby.
module cdsm_regs (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// Register port
	input  wire logic       wr_en_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	output logic      [7:0] rdata_out,
	// Control from the control register and state request
	input  wire logic       soft_reset_in,
	input  wire logic       go_active_in,
	input  wire logic       go_standby_in,
	// Fault detector events
	input  wire logic [4:0] fault_event_in,
	input  wire logic       die_hot_in,
	// Drive settings and state
	output logic            active_out,
	output logic            settle_one_period_out,
	output logic            linear_drive_out,
	output logic      [2:0] switching_rate_code_out,
	output logic      [7:0] resonance_setting_value_out
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CDSM_STANDBY = 2'b01,
		CDSM_ACTIVE  = 2'b10
	} cdsm_state_t;

	cdsm_state_t state_r;
	logic [cdsm_pkg::FAULT_WIDTH-1:0] fault_r;
	logic enter_active;
	logic thermal_block;

	assign thermal_block = fault_r[cdsm_pkg::THERMAL_TRIP_BIT] | die_hot_in;
	assign enter_active  = (state_r == CDSM_STANDBY) && go_active_in &&
		!thermal_block && !soft_reset_in;

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= CDSM_STANDBY;
		end else begin
			case (state_r)
				CDSM_STANDBY: begin
					if (enter_active) begin
						state_r <= CDSM_ACTIVE;
					end
				end
				CDSM_ACTIVE: begin
					if (soft_reset_in || go_standby_in || die_hot_in ||
						fault_event_in[cdsm_pkg::THERMAL_TRIP_BIT]) begin
						state_r <= CDSM_STANDBY;
					end
				end
				default: state_r <= CDSM_STANDBY;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fault flags
	// ----------------------------------------------------------------
	// Thermal flag stays up while the die is hot
	logic [cdsm_pkg::FAULT_WIDTH-1:0] fault_set;
	assign fault_set = fault_event_in |
		(5'(die_hot_in) << cdsm_pkg::THERMAL_TRIP_BIT);

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fault_r <= cdsm_pkg::FAULT_FLAGS_RST[cdsm_pkg::FAULT_WIDTH-1:0];
		end else if (soft_reset_in) begin
			// A fault reported in the same cycle survives the soft reset
			fault_r <= cdsm_pkg::FAULT_FLAGS_RST[cdsm_pkg::FAULT_WIDTH-1:0] |
				fault_set;
		end else if (enter_active) begin
			fault_r <= fault_set;
		end else begin
			fault_r <= fault_r | fault_set;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [cdsm_pkg::DRIVE_CONFIG_MASK_W-1:0] drive_config_r;
	logic [7:0] resonance_setting_r;

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			drive_config_r <=
				cdsm_pkg::DRIVE_CONFIG_RST[cdsm_pkg::DRIVE_CONFIG_MASK_W-1:0];
		end else if (soft_reset_in) begin
			drive_config_r <=
				cdsm_pkg::DRIVE_CONFIG_RST[cdsm_pkg::DRIVE_CONFIG_MASK_W-1:0];
		end else if (wr_en_in && addr_in == cdsm_pkg::DRIVE_CONFIG_ADDR) begin
			drive_config_r <= wdata_in[cdsm_pkg::DRIVE_CONFIG_MASK_W-1:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			resonance_setting_r <= cdsm_pkg::RESONANCE_SETTING_RST;
		end else if (soft_reset_in) begin
			resonance_setting_r <= cdsm_pkg::RESONANCE_SETTING_RST;
		end else if (wr_en_in && addr_in == cdsm_pkg::RESONANCE_SETTING_ADDR) begin
			resonance_setting_r <= wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Read path and outputs
	// ----------------------------------------------------------------
	logic [7:0] rdata_nxt;
	always_comb begin
		case (addr_in)
			cdsm_pkg::FAULT_FLAGS_ADDR:       rdata_nxt = {3'h0, fault_r};
			cdsm_pkg::DRIVE_CONFIG_ADDR:      rdata_nxt = {3'h0, drive_config_r};
			cdsm_pkg::RESONANCE_SETTING_ADDR: rdata_nxt = resonance_setting_r;
			default:                          rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_out                   <= 8'h00;
			active_out                  <= 1'b0;
			settle_one_period_out       <= 1'b0;
			linear_drive_out            <= 1'b0;
			switching_rate_code_out     <= cdsm_pkg::RATE_0M5;
			resonance_setting_value_out <= cdsm_pkg::RESONANCE_SETTING_RST;
		end else begin
			rdata_out                   <= rdata_nxt;
			active_out                  <= (state_r == CDSM_ACTIVE);
			settle_one_period_out       <=
				drive_config_r[cdsm_pkg::SETTLE_SEL_BIT];
			linear_drive_out            <=
				drive_config_r[cdsm_pkg::DRIVE_STYLE_BIT];
			switching_rate_code_out     <=
				drive_config_r[cdsm_pkg::RATE_MSB:cdsm_pkg::RATE_LSB];
			resonance_setting_value_out <= resonance_setting_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Drive-config write that no soft reset in the same cycle undoes
	sequence s_cfg_write;
		wr_en_in && addr_in == cdsm_pkg::DRIVE_CONFIG_ADDR && !soft_reset_in;
	endsequence

	// Thermal trip seen while active
	sequence s_thermal_active;
		state_r == CDSM_ACTIVE &&
			(die_hot_in || fault_event_in[cdsm_pkg::THERMAL_TRIP_BIT]);
	endsequence

	chk_clear_on_active: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		enter_active |=> ((fault_r & ~$past(fault_set)) == 5'h00))
		else $error("faults not cleared on activation");

	chk_thermal_holds: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		(state_r == CDSM_STANDBY && thermal_block) |=>
			state_r == CDSM_STANDBY)
		else $error("activated during thermal trip");

	chk_thermal_exit: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		s_thermal_active |=> state_r == CDSM_STANDBY)
		else $error("thermal trip did not force standby");

	chk_flag_sticky: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		(fault_set != 5'h00) |=>
			((fault_r & $past(fault_set)) == $past(fault_set)))
		else $error("reported fault not latched");

	chk_status_upper: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		(addr_in == cdsm_pkg::FAULT_FLAGS_ADDR) |=> rdata_out[7:5] == 3'h0)
		else $error("unused status bits set");

	chk_settle_sel: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		s_cfg_write |=> ##1
			settle_one_period_out == $past(wdata_in[0], 2))
		else $error("settling select mismatch");

	chk_drive_style: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		s_cfg_write |=> ##1
			linear_drive_out == $past(wdata_in[1], 2))
		else $error("drive style mismatch");

	chk_rate_code: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		s_cfg_write |=> ##1
			switching_rate_code_out == $past(wdata_in[4:2], 2))
		else $error("rate code mismatch");

	chk_soft_default: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		soft_reset_in |=> ##1
			(resonance_setting_value_out ==
			cdsm_pkg::RESONANCE_SETTING_RST && !active_out))
		else $error("soft reset not applied");

	chk_unmapped_zero: assert property (
		@(posedge clk_in) disable iff (!rst_n_r)
		(addr_in < cdsm_pkg::FAULT_FLAGS_ADDR ||
			addr_in > cdsm_pkg::RESONANCE_SETTING_ADDR) |=>
			rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### cdsm_host.sv
// Host model that reaches the register bank over its write and read port
`timescale 1ns/1ps
`default_nettype none
module cdsm_host (
	// Bus
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_en_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out
);
	initial begin
		wr_en_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h5a;
	end
	// Write data is inverted once released so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#2;
		wr_en_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#2;
		wr_en_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#2;
		addr_out = a;
		@(posedge clk_in);
		#2;
		d = rdata_in;
	endtask
	function automatic logic [7:0] res_code(input int f);
		return 8'(383 - (38400 + f) / (2 * f));
	endfunction
	function automatic logic settle_sel(input int spread);
		return spread <= 10;
	endfunction
endmodule
`default_nettype wire

// ### coil_driver_status_mode_regs_tb.sv
// Self-checking testbench of the fault, drive and resonance registers
`timescale 1ns/1ps
`default_nettype none
module coil_driver_status_mode_regs_tb;
	logic       clk_in = 1'b0;
	logic       resetn_in = 1'b0;
	logic       wr_en, srst = 1'b0, go_act = 1'b0, go_stb = 1'b0;
	logic       hot = 1'b0, act, settle, lin;
	logic [2:0] rate;
	logic [4:0] fev = 5'h00;
	logic [7:0] addr, wdata, rdata, res, rv;
	int         error_cnt = 0;
	int         comparisons = 0;
	int         cycles = 0;
	always #12.5 clk_in = ~clk_in;
	cdsm_regs uut (.clk_in(clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en),
		.addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
		.soft_reset_in(srst), .go_active_in(go_act), .go_standby_in(go_stb),
		.fault_event_in(fev), .die_hot_in(hot), .active_out(act),
		.settle_one_period_out(settle), .linear_drive_out(lin),
		.switching_rate_code_out(rate), .resonance_setting_value_out(res));
	cdsm_host host (.clk_in(clk_in), .rdata_in(rdata), .wr_en_out(wr_en),
		.addr_out(addr), .wdata_out(wdata));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rv);
		check(rv, exp);
	endtask
	task automatic final_report();
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic t_defaults();
		rdchk(8'h05, 8'h00);
		rdchk(8'h06, 8'h00);
		rdchk(8'h07, 8'h83);
		check({2'b00, act, settle, lin, rate}, 8'h00);
	endtask
	task automatic t_mode();
		for (int i = 0; i < 8; i++) begin
			host.wr(8'h06, {3'b111, 3'(i), 2'(i)});
			step(2);
			check({3'b000, rate, lin, settle}, {3'b000, 3'(i), 2'(i)});
			rdchk(8'h06, {3'b000, 3'(i), 2'(i)});
		end
		host.wr(8'h06, {7'h00, host.settle_sel(30)});
		step(2);
		check({7'h00, settle}, 8'h00);
		host.wr(8'h05, 8'hff);
		rdchk(8'h05, 8'h00);
		host.wr(8'h08, 8'haa);
		rdchk(8'h07, 8'h83);
		host.wr(8'h07, host.res_code(150));
		step(2);
		check(res, 8'hff);
		rdchk(8'h07, 8'hff);
	endtask
	task automatic t_faults();
		fev = 5'h0f;
		step(1);
		fev = 5'h00;
		rdchk(8'h05, 8'h0f);
		go_act = 1'b1;
		step(1);
		go_act = 1'b0;
		step(3);
		check({7'h00, act}, 8'h01);
		rdchk(8'h05, 8'h00);
		fev = 5'h10;
		hot = 1'b1;
		step(1);
		fev = 5'h00;
		step(3);
		check({7'h00, act}, 8'h00);
		hot = 1'b0;
		go_act = 1'b1;
		step(1);
		go_act = 1'b0;
		step(3);
		check({7'h00, act}, 8'h00);
		rdchk(8'h05, 8'h10);
		srst = 1'b1;
		step(1);
		srst = 1'b0;
		step(3);
		rdchk(8'h05, 8'h00);
		rdchk(8'h06, 8'h00);
		rdchk(8'h07, 8'h83);
		go_act = 1'b1;
		step(1);
		go_act = 1'b0;
		step(3);
		check({7'h00, act}, 8'h01);
		go_stb = 1'b1;
		step(1);
		go_stb = 1'b0;
		step(3);
		check({7'h00, act}, 8'h00);
		go_act = 1'b1;
		step(1);
		go_act = 1'b0;
		step(3);
		check({7'h00, act}, 8'h01);
		srst = 1'b1;
		step(1);
		srst = 1'b0;
		step(3);
		check({7'h00, act}, 8'h00);
	endtask
	initial begin
		step(20);
		resetn_in = 1'b1;
		step(3);
		t_defaults();
		t_mode();
		t_faults();
		final_report();
	end
endmodule
`default_nettype wire
